//--- src/ics_op_counter.sv
// Saturating ON-event counter with scaled limit check
`timescale 1ns/1ps
module ics_op_counter
  import ics_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic rst, // Async reset
  input wire logic en, // Count and error enable
  input wire logic level, // Channel ON state
  input wire logic load, // Restore pulse
  input wire logic [CNT_W-1:0] load_val, // Restored count
  input wire logic [LIM_W-1:0] limit, // Limit in thousands
  output logic [CNT_W-1:0] count, // Operation count
  output logic err // Limit exceeded
);
  logic lvl_q;
  logic rise;
  logic [CNT_W-1:0] lim_ops;
  logic [CNT_W-1:0] next_count;
  logic next_err;

  // Count rising ON edges, stop at full scale
  always_comb
  begin
    rise = level && !lvl_q;
    lim_ops = CNT_W'(limit) * CNT_W'(LIM_SCALE);
    next_count = count;
    if (load)
    begin
      next_count = load_val;
    end
    else if (en && rise && count != CNT_MAX)
    begin
      next_count = count + CNT_W'(1);
    end
    next_err = en && (count > lim_ops);
  end

  // State registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      lvl_q <= 1'b0;
      count <= '0;
      err <= 1'b0;
    end
    else
    begin
      lvl_q <= level;
      count <= next_count;
      err <= next_err;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  property p_sat;
    count == CNT_MAX && !load |=> count == CNT_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("count wrapped");

  property p_inc;
    en && !load && level && !lvl_q && count != CNT_MAX |=> count == $past(count) + CNT_W'(1);
  endproperty
  a_inc: assert property (p_inc) else $error("ON edge not counted");

  property p_dis;
    !en |=> !err;
  endproperty
  a_dis: assert property (p_dis) else $error("error while disabled");

  property p_load;
    load |=> count == $past(load_val);
  endproperty
  a_load: assert property (p_load) else $error("restore lost");
endmodule

//--- src/ics_pkg.sv
// Shared constants and types for the I/O channel supervisor
package ics_pkg;
  localparam int NV_CH = 4;
  localparam int IN_CH = 4;
  localparam int CNT_W = 32;
  localparam int LIM_W = 16;
  localparam int CFG_W = 10;
  localparam int TW = 12;
  localparam int SV_W = 26;
  localparam int LIM_SCALE = 1000;
  localparam logic [CNT_W-1:0] CNT_MAX = '1;
  localparam logic [LIM_W-1:0] LIM_RST = 16'h0001;
  // Shared config field positions
  localparam int F_CV = 0;
  localparam int F_OV = 1;
  localparam int F_SC = 2;
  localparam int F_RS = 3;
  localparam int F_SS = 4;
  localparam int F_IR = 5;
  localparam int F_FT = 6;
  localparam int F_ST = 8;
  localparam logic [CFG_W-1:0] CFG_RST = 10'h157;
  // Timing base
  localparam int CLK_NS = 25;
  localparam int TICK_NS = 100000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int NS_PER_US = 1000;
  localparam int US_PER_TICK = TICK_NS / NS_PER_US;
  localparam int US_PER_S = 1000000;
  localparam int FILT_US [4] = '{100, 1000, 10000, 20000};
  localparam int STR_US [4] = '{1000, 15000, 100000, 200000};
  localparam int INRUSH_US = 100000;
  localparam int INRUSH_TK = INRUSH_US / US_PER_TICK;
  localparam int VSAVE_S = 30;
  localparam int ISAVE_S = 3600;
  localparam int VSAVE_TK = VSAVE_S * (US_PER_S / US_PER_TICK);
  localparam int ISAVE_TK = ISAVE_S * (US_PER_S / US_PER_TICK);
  // Output behaviour during fault or idle
  typedef enum logic [1:0] {OM_CLEAR = 2'h0, OM_HOLD = 2'h1, OM_FORCED_ON = 2'h2} ics_omode_t;

  function automatic logic [TW-1:0] filt_ticks(input logic [1:0] s);
    return TW'(FILT_US[s] / US_PER_TICK);
  endfunction

  function automatic logic [TW-1:0] str_ticks(input logic [1:0] s);
    return TW'(STR_US[s] / US_PER_TICK);
  endfunction
endpackage

//--- src/ics_supervisor.sv
// I/O channel supervisor: supply, short, open and count checks, outputs
// Contract
// - Control supply out of range gives unit error
// - Output supply out of range gives unit error
// - Valve short error raised only when check enabled
// - Auto restart clears short error when gone, unless a manual latch was set since power-up
// - Manual restart latches short until power-up
// - Valve open wire channel error, terminal only
// - Per-channel fault/idle output clear, hold, on
// - Channel selections act only under handheld priority
// - Valve ON count error above scaled limit
// - Save valve counts every 30 s, restore
// - Sensor supply short gives unit error
// - Input open wire channel error, terminal only
// - Inrush filter masks excess current 100 ms
// - Ignore input changes shorter than filter time
// - Stretch detected input for selected time
// - Input ON counter, limit error, hourly save
// - Most recent parameter write wins
// - Master values restored when comm returns
`timescale 1ns/1ps
module ics_supervisor
  import ics_pkg::*;
#(
  parameter logic [SV_W-1:0] VSAVE_TICKS = SV_W'(VSAVE_TK), // Valve save period
  parameter logic [SV_W-1:0] ISAVE_TICKS = SV_W'(ISAVE_TK) // Input save period
)
(
  input wire logic mclk, // 40 MHz clock
  input wire logic rst, // Async reset, high
  input wire logic m_wr, // Master parameter write
  input wire logic [CFG_W-1:0] m_cfg, // Master parameter values
  input wire logic t_wr, // Terminal parameter write
  input wire logic [CFG_W-1:0] t_cfg, // Terminal shared values
  input wire logic t_open_wire, // Valve open wire check
  input wire logic t_in_open, // Input open wire check
  input wire logic [2*NV_CH-1:0] t_fault_sel, // Fault mode per channel
  input wire logic [2*NV_CH-1:0] t_idle_sel, // Idle mode per channel
  input wire logic t_vcnt_en, // Valve counter enable
  input wire logic [LIM_W-1:0] t_vlimit, // Valve limit, thousands
  input wire logic t_icnt_en, // Input counter enable
  input wire logic [LIM_W-1:0] t_ilimit, // Input limit, thousands
  input wire logic hold_prio_handheld, // Priority set to handheld
  input wire logic sw_hold, // Unit switch holds outputs
  input wire logic comm_fault, // Fieldbus fault
  input wire logic comm_idle, // Fieldbus idle
  input wire logic [NV_CH-1:0] valve_cmd, // Commanded valve states
  input wire logic ctrl_v_high, // Control supply high
  input wire logic ctrl_v_low, // Control supply low
  input wire logic out_v_high, // Output supply high
  input wire logic out_v_low, // Output supply low
  input wire logic valve_short, // Valve short detected
  input wire logic [NV_CH-1:0] valve_open, // Valve wire open
  input wire logic sens_short, // Sensor supply short
  input wire logic sens_pwr_on, // Sensor supply switched on
  input wire logic [IN_CH-1:0] in_open, // Input wire open
  input wire logic [IN_CH-1:0] in_raw, // Raw input pins
  input wire logic nv_load, // Restore counts pulse
  input wire logic [NV_CH*CNT_W-1:0] nv_vcnt, // Saved valve counts
  input wire logic [IN_CH*CNT_W-1:0] nv_icnt, // Saved input counts
  output logic [NV_CH-1:0] valve_out, // Valve drive
  output logic [IN_CH-1:0] in_level, // Conditioned inputs
  output logic [CFG_W-1:0] cfg, // Active shared parameters
  output logic ctrl_volt_err, // Control supply error
  output logic out_volt_err, // Output supply error
  output logic short_err, // Valve short error
  output logic [NV_CH-1:0] open_err, // Valve open errors
  output logic sens_short_err, // Sensor supply short error
  output logic [IN_CH-1:0] in_open_err, // Input open errors
  output logic [NV_CH-1:0] vcnt_err, // Valve count errors
  output logic [IN_CH-1:0] icnt_err, // Input count errors
  output logic [NV_CH*CNT_W-1:0] vcnt, // Valve counts
  output logic [IN_CH*CNT_W-1:0] icnt, // Input counts
  output logic valve_save, // Store valve counts pulse
  output logic in_save // Store input counts pulse
);
  localparam int PIN_W = 7 + NV_CH + 2 * IN_CH;

  logic [PIN_W-1:0] pin_raw, pin_m, pin_s;
  logic s_cvh, s_cvl, s_ovh, s_ovl, s_vsh, s_ssh, s_pwr;
  logic [NV_CH-1:0] s_vop;
  logic [IN_CH-1:0] s_iop, in_s;

  // Pin inputs through two flip-flops
  assign pin_raw = {in_raw, in_open, valve_open, sens_pwr_on, sens_short, valve_short,
                    out_v_low, out_v_high, ctrl_v_low, ctrl_v_high};
  assign {in_s, s_iop, s_vop, s_pwr, s_ssh, s_vsh, s_ovl, s_ovh, s_cvl, s_cvh} = pin_s;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pin_m <= '0;
      pin_s <= '0;
    end
    else
    begin
      pin_m <= pin_raw;
      pin_s <= pin_m;
    end
  end

  // Parameter store: shared fields, master shadow, terminal-only fields
  logic [CFG_W-1:0] shadow, next_cfg, next_shadow;
  logic open_check, in_open_check, vcnt_en, icnt_en, fault_q, comm_back;
  logic [2*NV_CH-1:0] fault_sel, idle_sel;
  logic [LIM_W-1:0] vlimit, ilimit;

  always_comb
  begin
    comm_back = fault_q && !comm_fault;
    next_cfg = cfg;
    next_shadow = shadow;
    if (t_wr)
    begin
      next_cfg = t_cfg;
    end
    if (m_wr)
    begin
      next_cfg = m_cfg;
      next_shadow = m_cfg;
    end
    if (comm_back)
    begin
      next_cfg = next_shadow;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cfg <= CFG_RST;
      shadow <= CFG_RST;
      fault_q <= 1'b0;
      open_check <= 1'b0;
      in_open_check <= 1'b0;
      fault_sel <= {NV_CH{OM_CLEAR}};
      idle_sel <= {NV_CH{OM_CLEAR}};
      vcnt_en <= 1'b0;
      icnt_en <= 1'b0;
      vlimit <= LIM_RST;
      ilimit <= LIM_RST;
    end
    else
    begin
      cfg <= next_cfg;
      shadow <= next_shadow;
      fault_q <= comm_fault;
      if (t_wr)
      begin
        open_check <= t_open_wire;
        in_open_check <= t_in_open;
        fault_sel <= t_fault_sel;
        idle_sel <= t_idle_sel;
        vcnt_en <= t_vcnt_en;
        icnt_en <= t_icnt_en;
        vlimit <= t_vlimit;
        ilimit <= t_ilimit;
      end
    end
  end

  // Time base and periodic save strobes
  logic [TW-1:0] tick_cnt, next_tick_cnt, blank, next_blank;
  logic [SV_W-1:0] vsv, isv, next_vsv, next_isv;
  logic tick, pwr_q, next_vsave, next_isave;

  always_comb
  begin
    tick = (tick_cnt == TW'(TICK_CYC - 1));
    next_tick_cnt = tick ? '0 : tick_cnt + TW'(1);
    next_vsv = vsv;
    next_isv = isv;
    next_vsave = 1'b0;
    next_isave = 1'b0;
    if (tick)
    begin
      next_vsave = (vsv == VSAVE_TICKS - SV_W'(1));
      next_isave = (isv == ISAVE_TICKS - SV_W'(1));
      next_vsv = next_vsave ? '0 : vsv + SV_W'(1);
      next_isv = next_isave ? '0 : isv + SV_W'(1);
    end
    next_blank = (blank != '0 && tick) ? blank - TW'(1) : blank;
    if (cfg[F_IR] && s_pwr && !pwr_q)
    begin
      next_blank = TW'(INRUSH_TK + 1);
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt <= '0;
      vsv <= '0;
      isv <= '0;
      valve_save <= 1'b0;
      in_save <= 1'b0;
      blank <= '0;
      pwr_q <= 1'b0;
    end
    else
    begin
      tick_cnt <= next_tick_cnt;
      vsv <= next_vsv;
      isv <= next_isv;
      valve_save <= next_vsave;
      in_save <= next_isave;
      blank <= next_blank;
      pwr_q <= s_pwr;
    end
  end

  // Error flags
  logic next_cv, next_ov, next_sc, next_ss, sc_hold, next_sc_hold;

  always_comb
  begin
    next_cv = cfg[F_CV] && (s_cvh || s_cvl);
    next_ov = cfg[F_OV] && (s_ovh || s_ovl);
    next_sc = cfg[F_SC] && s_vsh;
    // A latched short survives a later switch back to automatic restart
    if (cfg[F_RS] || sc_hold)
    begin
      next_sc = short_err || next_sc;
    end
    next_sc_hold = sc_hold || (cfg[F_RS] && next_sc);
    next_ss = cfg[F_SS] && s_ssh && (blank == '0);
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_volt_err <= 1'b0;
      out_volt_err <= 1'b0;
      short_err <= 1'b0;
      sc_hold <= 1'b0;
      sens_short_err <= 1'b0;
      open_err <= '0;
      in_open_err <= '0;
    end
    else
    begin
      ctrl_volt_err <= next_cv;
      out_volt_err <= next_ov;
      short_err <= next_sc;
      sc_hold <= next_sc_hold;
      sens_short_err <= next_ss;
      open_err <= open_check ? s_vop : '0;
      in_open_err <= in_open_check ? s_iop : '0;
    end
  end

  // Valve drive under fault and idle
  logic [NV_CH-1:0] next_vout;
  ics_omode_t mode;

  always_comb
  begin
    next_vout = valve_cmd;
    mode = OM_CLEAR;
    for (int i = 0; i < NV_CH; i++)
    begin
      if (comm_fault || comm_idle)
      begin
        if (hold_prio_handheld)
        begin
          mode = ics_omode_t'(comm_fault ? fault_sel[2*i +: 2] : idle_sel[2*i +: 2]);
        end
        else
        begin
          mode = sw_hold ? OM_HOLD : OM_CLEAR;
        end
        unique case (mode)
          OM_CLEAR: next_vout[i] = 1'b0;
          OM_HOLD: next_vout[i] = valve_out[i];
          OM_FORCED_ON: next_vout[i] = 1'b1;
          default: next_vout[i] = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      valve_out <= '0;
    end
    else
    begin
      valve_out <= next_vout;
    end
  end

  // Input debounce and stretch per channel
  logic [TW-1:0] filt_tk, str_tk;
  assign filt_tk = filt_ticks(cfg[F_FT +: 2]);
  assign str_tk = str_ticks(cfg[F_ST +: 2]);

  genvar gi;
  generate
    for (gi = 0; gi < IN_CH; gi++)
    begin : g_in
      logic filt, next_filt, lvl, next_lvl;
      logic [TW-1:0] fcnt, next_fcnt, hcnt, next_hcnt;

      always_comb
      begin
        next_filt = filt;
        next_fcnt = '0;
        if (in_s[gi] != filt)
        begin
          next_fcnt = tick ? fcnt + TW'(1) : fcnt;
          // One extra tick boundary so no change shorter than the filter time passes
          if (fcnt > filt_tk)
          begin
            next_filt = in_s[gi];
            next_fcnt = '0;
          end
        end
        next_hcnt = (hcnt != '0 && tick) ? hcnt - TW'(1) : hcnt;
        if (next_filt && !filt)
        begin
          next_hcnt = str_tk + TW'(1);
        end
        next_lvl = next_filt || (next_hcnt != '0);
      end

      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          filt <= 1'b0;
          fcnt <= '0;
          hcnt <= '0;
          lvl <= 1'b0;
        end
        else
        begin
          filt <= next_filt;
          fcnt <= next_fcnt;
          hcnt <= next_hcnt;
          lvl <= next_lvl;
        end
      end

      assign in_level[gi] = lvl;

      // Input ON counter
      ics_op_counter u_icnt (
        .mclk(mclk),
        .rst(rst),
        .en(icnt_en),
        .level(lvl),
        .load(nv_load),
        .load_val(nv_icnt[gi*CNT_W +: CNT_W]),
        .limit(ilimit),
        .count(icnt[gi*CNT_W +: CNT_W]),
        .err(icnt_err[gi])
      );
    end
  endgenerate

  // Valve ON counters
  genvar gv;
  generate
    for (gv = 0; gv < NV_CH; gv++)
    begin : g_vc
      ics_op_counter u_vcnt (
        .mclk(mclk),
        .rst(rst),
        .en(vcnt_en),
        .level(valve_out[gv]),
        .load(nv_load),
        .load_val(nv_vcnt[gv*CNT_W +: CNT_W]),
        .limit(vlimit),
        .count(vcnt[gv*CNT_W +: CNT_W]),
        .err(vcnt_err[gv])
      );
    end
  endgenerate

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  property p_cv;
    cfg[F_CV] && (s_cvh || s_cvl) |=> ctrl_volt_err;
  endproperty
  a_cv: assert property (p_cv) else $error("control supply error missing");

  property p_ov_off;
    !cfg[F_OV] |=> !out_volt_err;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("output supply error when off");

  property p_sc_dis;
    !cfg[F_SC] && !short_err |=> !short_err;
  endproperty
  a_sc_dis: assert property (p_sc_dis) else $error("short error when off");

  property p_auto;
    !cfg[F_RS] && !sc_hold && !s_vsh |=> !short_err;
  endproperty
  a_auto: assert property (p_auto) else $error("auto restart did not clear");

  property p_manual;
    cfg[F_RS] && short_err |=> short_err [*2];
  endproperty
  a_manual: assert property (p_manual) else $error("manual latch released");

  property p_open;
    !open_check |=> open_err == '0;
  endproperty
  a_open: assert property (p_open) else $error("open error when off");

  property p_force;
    hold_prio_handheld && comm_fault && fault_sel[5:4] == OM_FORCED_ON |=> valve_out[2];
  endproperty
  a_force: assert property (p_force) else $error("forced on not applied");

  property p_prio;
    !hold_prio_handheld && comm_idle && !sw_hold |=> valve_out == '0;
  endproperty
  a_prio: assert property (p_prio) else $error("selection used without priority");

  property p_inrush;
    blank != '0 |=> !sens_short_err;
  endproperty
  a_inrush: assert property (p_inrush) else $error("error inside inrush window");

  property p_latest;
    t_wr && !m_wr && !comm_back |=> cfg == $past(t_cfg);
  endproperty
  a_latest: assert property (p_latest) else $error("terminal write not applied");

  property p_reload;
    comm_back && !m_wr |=> cfg == $past(shadow);
  endproperty
  a_reload: assert property (p_reload) else $error("master values not restored");

  c_hold: cover property (hold_prio_handheld && comm_fault ##1 valve_out != '0);
  c_latch: cover property (cfg[F_RS] && short_err && !s_vsh);
  c_save: cover property (valve_save);
endmodule

//--- verif/ics_field_model.sv
// Field-side model: supply monitors, valve wiring and one sensor
`timescale 1ns/1ps
module ics_field_model
  import ics_pkg::*;
(
  input wire logic [15:0] ctrl_mv, // Control supply, mV
  input wire logic [15:0] out_mv, // Output supply, mV
  input wire logic inj_short, // Valve short present
  input wire logic [NV_CH-1:0] inj_open, // Broken valve wires
  input wire logic sens_on, // Sensor sees its target
  output logic ctrl_v_high, // Control supply high
  output logic ctrl_v_low, // Control supply low
  output logic out_v_high, // Output supply high
  output logic out_v_low, // Output supply low
  output logic valve_short, // Short flag to the unit
  output logic [NV_CH-1:0] valve_open, // Open flags to the unit
  output logic [IN_CH-1:0] in_raw // Sensor pins, all channels wired alike
);
  // Supply comparators at the documented trip points
  assign ctrl_v_high = ctrl_mv > 16'h6590;
  assign ctrl_v_low = ctrl_mv < 16'h5208;
  assign out_v_high = out_mv > 16'h6590;
  assign out_v_low = out_mv < 16'h4e20;
  // Wiring faults and sensor levels
  assign valve_short = inj_short;
  assign valve_open = inj_open;
  assign in_raw = {IN_CH{sens_on}};
endmodule

//--- verif/tb_top.sv
// Self-checking testbench for the I/O channel supervisor
`timescale 1ns/1ps
`define CMP(n, e, g) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("ERROR %s expected %h seen %h", n, e, g); \
    end \
  end
module tb_top
  import ics_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic m_wr = 1'b0, t_wr = 1'b0, t_open_wire = 1'b0, t_in_open = 1'b0;
  logic t_vcnt_en = 1'b0, t_icnt_en = 1'b0, hold_prio_handheld = 1'b0, sw_hold = 1'b0;
  logic comm_fault = 1'b0, comm_idle = 1'b0, sens_short = 1'b0, sens_pwr_on = 1'b0;
  logic nv_load = 1'b0, inj_short = 1'b0, sens_on = 1'b0;
  logic [CFG_W-1:0] m_cfg = '0, t_cfg = '0, cfg;
  logic [2*NV_CH-1:0] t_fault_sel = '0, t_idle_sel = '0;
  logic [LIM_W-1:0] t_vlimit = 16'h0001, t_ilimit = 16'h0001;
  logic [NV_CH-1:0] valve_cmd = '0, inj_open = '0, valve_open, valve_out, open_err, vcnt_err;
  logic [IN_CH-1:0] in_open = '0, in_raw, in_level, in_open_err, icnt_err;
  logic [15:0] ctrl_mv = 16'h5dc0, out_mv = 16'h5dc0;
  logic [NV_CH*CNT_W-1:0] nv_vcnt = '0, vcnt;
  logic [IN_CH*CNT_W-1:0] nv_icnt = '0, icnt;
  logic ctrl_v_high, ctrl_v_low, out_v_high, out_v_low, valve_short;
  logic ctrl_volt_err, out_volt_err, short_err, sens_short_err, valve_save, in_save;
  logic [31:0] e;
  logic [3:0] p;
  int fail_count = 0, comparisons = 0, seed = 32'hafd7, i, s, cycles;
  int q_sel[$];
  logic [31:0] q_exp[$];
  event take;
  string nm [12] = '{"cfg", "ctrl_volt_err", "out_volt_err", "short_err", "valve_out",
    "vcnt0", "vcnt_err", "valve_save", "in_level", "sens_short_err", "open_err", "icnt0"};
  logic [15:0] mv [3] = '{16'h6978, 16'h5014, 16'h5dc0};

  ics_field_model u_field (.ctrl_mv, .out_mv, .inj_short, .inj_open, .sens_on, .ctrl_v_high,
    .ctrl_v_low, .out_v_high, .out_v_low, .valve_short, .valve_open, .in_raw);
  ics_supervisor #(.VSAVE_TICKS(26'h3), .ISAVE_TICKS(26'h5)) u_dut (.mclk, .rst, .m_wr,
    .m_cfg, .t_wr, .t_cfg, .t_open_wire, .t_in_open, .t_fault_sel, .t_idle_sel, .t_vcnt_en,
    .t_vlimit, .t_icnt_en, .t_ilimit, .hold_prio_handheld, .sw_hold, .comm_fault,
    .comm_idle, .valve_cmd, .ctrl_v_high, .ctrl_v_low, .out_v_high, .out_v_low,
    .valve_short, .valve_open, .sens_short, .sens_pwr_on, .in_open, .in_raw, .nv_load,
    .nv_vcnt, .nv_icnt, .valve_out, .in_level, .cfg, .ctrl_volt_err, .out_volt_err,
    .short_err, .open_err, .sens_short_err, .in_open_err, .vcnt_err, .icnt_err, .vcnt,
    .icnt, .valve_save, .in_save);

  // Observed output picked by note index
  function automatic logic [31:0] seen(input int k);
    case (k)
      0: seen = 32'(cfg);
      1: seen = 32'(ctrl_volt_err);
      2: seen = 32'(out_volt_err);
      3: seen = 32'(short_err);
      4: seen = 32'(valve_out);
      5: seen = vcnt[31:0];
      6: seen = 32'(vcnt_err);
      7: seen = 32'(valve_save);
      8: seen = 32'(in_level);
      9: seen = 32'(sens_short_err);
      11: seen = icnt[31:0];
      default: seen = {24'h0, in_open_err, open_err};
    endcase
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Driver side records what it expects now
  task automatic note(input int k, input logic [31:0] v);
    q_sel.push_back(k);
    q_exp.push_back(v);
    -> take;
  endtask

  task automatic mwrite(input logic [9:0] v);
    m_cfg = v;
    m_wr = 1'b1;
    cyc(1);
    m_wr = 1'b0;
    cyc(1);
  endtask

  // Terminal write also carries every terminal-only setting
  task automatic twrite(input logic [9:0] v);
    t_cfg = v;
    t_wr = 1'b1;
    cyc(1);
    t_wr = 1'b0;
    cyc(1);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Clock, 25 ns period
  initial
  begin
    forever
      #12.5 mclk = ~mclk;
  end

  // Monitor: compares outputs against the oldest notes
  initial
  begin
    forever
    begin
      @(take);
      while (q_sel.size() > 0)
      begin
        s = q_sel.pop_front();
        e = q_exp.pop_front();
        `CMP(nm[s], e, seen(s))
      end
    end
  end

  // Hang guard
  initial
  begin
    for (cycles = 0; cycles < 100000; cycles++)
      @(posedge mclk);
    fail_count++;
    give_verdict();
  end

  // Main sequence
  initial
  begin
    cyc(12);
    rst = 1'b0;
    cyc(2);
    note(0, 32'h157);
    for (i = 0; i < 3; i++)
    begin
      ctrl_mv = mv[i];
      out_mv = mv[i];
      cyc(5);
      note(1, 32'(i < 2));
      note(2, 32'(i == 0));
    end
    mwrite(10'h154);
    ctrl_mv = 16'h6978;
    out_mv = 16'h4a38;
    cyc(5);
    note(0, 32'h154);
    note(1, 32'h0);
    note(2, 32'h0);
    ctrl_mv = 16'h5dc0;
    out_mv = 16'h5dc0;
    // Short detection, auto then manual restart
    inj_short = 1'b1;
    cyc(5);
    note(3, 32'h1);
    inj_short = 1'b0;
    cyc(5);
    note(3, 32'h0);
    mwrite(10'h150);
    inj_short = 1'b1;
    cyc(5);
    note(3, 32'h0);
    inj_short = 1'b0;
    cyc(3);
    twrite(10'h15c);
    note(0, 32'h15c);
    inj_short = 1'b1;
    cyc(5);
    inj_short = 1'b0;
    cyc(5);
    note(3, 32'h1);
    comm_fault = 1'b1;
    cyc(2);
    comm_fault = 1'b0;
    cyc(3);
    note(0, 32'h150);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(2);
    note(3, 32'h0);
    note(0, 32'h157);
    // Open wire checks, terminal only
    inj_open = 4'ha;
    in_open = 4'h5;
    cyc(5);
    note(10, 32'h0);
    t_open_wire = 1'b1;
    t_in_open = 1'b1;
    twrite(10'h157);
    cyc(4);
    note(10, 32'h5a);
    inj_open = 4'h0;
    in_open = 4'h0;
    // Sensor supply short and inrush masking
    sens_short = 1'b1;
    cyc(5);
    note(9, 32'h1);
    twrite(10'h147);
    cyc(3);
    note(9, 32'h0);
    twrite(10'h177);
    cyc(3);
    note(9, 32'h1);
    sens_pwr_on = 1'b1;
    cyc(6);
    note(9, 32'h0);
    sens_short = 1'b0;
    // Per-channel fault and idle output modes
    t_fault_sel = 8'he4;
    t_idle_sel = 8'h52;
    hold_prio_handheld = 1'b1;
    twrite(10'h157);
    valve_cmd = 4'($random(seed));
    cyc(2);
    p = valve_cmd;
    comm_fault = 1'b1;
    valve_cmd = 4'($random(seed));
    cyc(2);
    note(4, {28'h0, 1'b0, 1'b1, p[1], 1'b0});
    comm_fault = 1'b0;
    cyc(2);
    p = valve_cmd;
    comm_idle = 1'b1;
    valve_cmd = 4'($random(seed));
    cyc(2);
    note(4, {28'h0, p[3], p[2], 1'b0, 1'b1});
    hold_prio_handheld = 1'b0;
    cyc(2);
    note(4, 32'h0);
    comm_idle = 1'b0;
    cyc(2);
    p = valve_cmd;
    sw_hold = 1'b1;
    comm_idle = 1'b1;
    valve_cmd = ~p;
    cyc(2);
    note(4, {28'h0, p});
    comm_idle = 1'b0;
    sw_hold = 1'b0;
    valve_cmd = 4'h0;
    cyc(2);
    // Valve operation counter against a limit of one thousand
    t_vcnt_en = 1'b1;
    twrite(10'h157);
    for (i = 0; i < 1001; i++)
    begin
      valve_cmd = 4'h1;
      cyc(1);
      valve_cmd = 4'h0;
      cyc(1);
      if (i == 999)
      begin
        cyc(2);
        note(5, 32'h3e8);
        note(6, 32'h0);
      end
    end
    cyc(3);
    note(5, 32'h3e9);
    note(6, 32'h1);
    nv_vcnt = {4{32'hfffffffe}};
    nv_load = 1'b1;
    cyc(1);
    nv_load = 1'b0;
    cyc(1);
    note(5, 32'hfffffffe);
    for (i = 0; i < 2; i++)
    begin
      valve_cmd = 4'h1;
      cyc(1);
      valve_cmd = 4'h0;
      cyc(1);
    end
    cyc(2);
    note(5, 32'hffffffff);
    for (i = 0; i < 13000 && valve_save !== 1'b1; i++)
      cyc(1);
    note(7, 32'h1);
    cyc(1);
    note(7, 32'h0);
    // Input filter rejects a pulse shorter than the 1000 us filter, passes a shorter one under the 100 us filter, then stretch
    t_icnt_en = 1'b1;
    twrite(10'h057);
    sens_on = 1'b1;
    cyc(16000);
    note(8, 32'h0);
    sens_on = 1'b0;
    cyc(100);
    // Shortest filter: the stretch alone must hold the level after the filter drops
    twrite(10'h017);
    sens_on = 1'b1;
    cyc(12000);
    note(8, 32'hf);
    sens_on = 1'b0;
    cyc(16000);
    note(8, 32'hf);
    cyc(28000);
    note(8, 32'h0);
    note(11, 32'h1);
    cyc(1);
    give_verdict();
  end
endmodule
